/* File: src/isp_pkg.sv */
// Shared constants and types for the program memory self-writer
package isp_pkg;
    // Array geometry
    localparam int unsigned MEM_BYTES       = 4096;
    localparam int unsigned PAGE_COUNT      = 128;
    localparam int unsigned PAGE_BYTES      = 32;
    localparam int unsigned PAGE_SHIFT      = 5;
    localparam int unsigned MEM_ADDR_W      = 12;
    localparam int unsigned RAM_ADDR_W      = 8;
    localparam int unsigned LEN_W           = 6;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_COMMAND     = 8'h94;
    localparam logic [7:0]  IDX_TARGET_LOW  = 8'h95;
    localparam logic [7:0]  IDX_TARGET_HIGH = 8'h96;
    localparam logic [7:0]  IDX_BUFFER_PTR  = 8'h97;
    localparam logic [7:0]  IDX_STATUS      = 8'h98;
    localparam int unsigned BUS_ADDR_W      = 10;

    // Reset values
    localparam logic [7:0]  RST_TARGET_LOW  = 8'h00;
    localparam logic [7:0]  RST_TARGET_HIGH = 8'h00;
    localparam logic [7:0]  RST_BUFFER_PTR  = 8'h00;

    // Command codes
    localparam logic [7:0]  CMD_PAGE        = 8'h5A;
    localparam logic [7:0]  CMD_BYTE        = 8'h1E;

    // Transfer lengths
    localparam logic [LEN_W-1:0] LEN_PAGE   = 6'h20;
    localparam logic [LEN_W-1:0] LEN_BYTE   = 6'h01;

    // Status field positions
    localparam int unsigned ST_BUSY_BIT     = 0;
    localparam int unsigned ST_PAGE_BIT     = 1;
    localparam int unsigned ST_DONE_BIT     = 2;

    // FIFO sizing
    localparam int unsigned FIFO_DEPTH      = 4;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_COPY  = 2'b01,
        ST_DRAIN = 2'b10
    } seq_state_t;

    // One byte headed for the array
    typedef struct packed {
        logic [MEM_ADDR_W-1:0] addr;
        logic [7:0]            data;
    } mem_write_t;

    // Software-visible setup registers
    typedef struct packed {
        logic [7:0] target_high;
        logic [7:0] target_low;
        logic [7:0] buffer_ptr;
    } setup_regs_t;
endpackage

/* File: src/program_memory_self_writer.sv */
// Program memory self-writer: register slave, copy sequencer and write FIFO
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps

// How it works
// - Array is 128 pages of 32 bytes
// - Page write takes page from address 11:5
// - Byte write reads one RAM byte at pointer
// - Byte write uses address bits 11:0; bits 15:12 dropped
// - Code 5A starts page write
// - Code 1E starts byte write
// - Trigger copies RAM buffer into memory
// - Buffer pointer: 8-bit, read/write, resets zero
// - Every page, first and last, is writable

// Small synchronous FIFO with valid/ready on both sides
module isp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // Flags come straight from the count, so full and empty never lie
    always_comb begin
        in_ready  = (cnt_q != (PW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        out_data  = mem_q[rd_q];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_d      = push ? ((wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d      = pop ? ((rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d     = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    // Pointers and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage needs no reset; empty flag guards stale words
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// Top: Avalon-MM register slave plus copy sequencer
module program_memory_self_writer #(
    parameter int unsigned FIFO_WORDS = isp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                                  REF_CLK,
    input  wire logic                                  RESET_N,
    // Avalon-MM register slave
    input  wire logic [isp_pkg::BUS_ADDR_W-1:0]        AVS_ADDRESS,
    input  wire logic                                  AVS_READ,
    input  wire logic                                  AVS_WRITE,
    input  wire logic [31:0]                           AVS_WRITEDATA,
    input  wire logic [3:0]                            AVS_BYTEENABLE,
    output logic [31:0]                                AVS_READDATA,
    output logic                                       AVS_WAITREQUEST,
    // Internal data RAM read port, one cycle latency
    output logic [isp_pkg::RAM_ADDR_W-1:0]             RAM_ADDR,
    output logic                                       RAM_RD,
    input  wire logic [7:0]                            RAM_RDATA,
    // Program memory array write port
    output logic [isp_pkg::MEM_ADDR_W-1:0]             MEM_ADDR,
    output logic [7:0]                                 MEM_WDATA,
    output logic                                       MEM_WE,
    input  wire logic                                  MEM_READY,
    // CPU fetch hold
    output logic                                       CPU_HOLD
);
    import isp_pkg::*;

    setup_regs_t           regs_q, regs_d;
    seq_state_t            state_q, state_d;
    logic                  page_mode_q, page_mode_d;
    logic                  done_q, done_d;
    logic [LEN_W-1:0]      len_q, len_d;
    logic [LEN_W-1:0]      rd_cnt_q, rd_cnt_d;
    logic [LEN_W-1:0]      wr_cnt_q, wr_cnt_d;
    logic [15:0]           base_q, base_d;
    logic [7:0]            ptr_q, ptr_d;
    logic                  ram_rd_q, ram_rd_d;
    logic                  ram_vld_q, ram_vld_d;
    logic [RAM_ADDR_W-1:0] ram_addr_q, ram_addr_d;
    logic                  wait_q, wait_d;
    logic [31:0]           rdata_q, rdata_d;
    logic                  mem_we_q, mem_we_d;
    mem_write_t            mem_q, mem_d;
    logic                  hold_q, hold_d;

    logic                  fifo_in_ready, fifo_out_valid, fifo_pop;
    mem_write_t            fifo_in, fifo_out;
    logic [7:0]            idx;
    logic                  access, commit_wr, lane0;

    // Register index from a word-aligned byte address
    function automatic logic [7:0] reg_index(input logic [BUS_ADDR_W-1:0] a);
        return a[BUS_ADDR_W-1:2];
    endfunction

    // Byte address of the n-th byte of the transfer
    function automatic logic [MEM_ADDR_W-1:0] dest_addr(input logic [15:0] base,
                                                        input logic [LEN_W-1:0] n);
        return MEM_ADDR_W'(base) + MEM_ADDR_W'(n);
    endfunction

    assign idx       = reg_index(AVS_ADDRESS);
    assign access    = AVS_READ || AVS_WRITE;
    // Write takes effect on the edge where waitrequest is seen low
    assign commit_wr = AVS_WRITE && !wait_q;
    assign lane0     = AVS_BYTEENABLE[0];

    // Bytes read from RAM enter the FIFO one cycle after the strobe
    // The RAM answers a cycle late, so the data cycle follows the strobe cycle
    assign fifo_in.addr = dest_addr(base_q, rd_cnt_q - 1'b1);
    assign fifo_in.data = RAM_RDATA;
    // One array write in flight at a time; next pops once it is gone
    assign fifo_pop     = fifo_out_valid && MEM_READY && !mem_we_q;

    isp_fifo #(
        .WIDTH ($bits(mem_write_t)),
        .DEPTH (FIFO_WORDS)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_n     (RESET_N),
        .in_valid  (ram_vld_q),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    // Bus slave: one wait state, and held off entirely while copying
    always_comb begin
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        regs_d  = regs_q;
        if (access && wait_q && state_q == ST_IDLE) begin
            wait_d  = 1'b0;
            rdata_d = 32'h0000_0000;
            case (idx)
                IDX_TARGET_LOW:  rdata_d = {24'h00_0000, regs_q.target_low};
                IDX_TARGET_HIGH: rdata_d = {24'h00_0000, regs_q.target_high};
                IDX_BUFFER_PTR:  rdata_d = {24'h00_0000, regs_q.buffer_ptr};
                IDX_STATUS: begin
                    rdata_d[ST_BUSY_BIT] = hold_q;
                    rdata_d[ST_PAGE_BIT] = page_mode_q;
                    rdata_d[ST_DONE_BIT] = done_q;
                end
                default:         rdata_d = 32'h0000_0000;
            endcase
        end
        if (commit_wr && lane0) begin
            case (idx)
                IDX_TARGET_LOW:  regs_d.target_low  = AVS_WRITEDATA[7:0];
                IDX_TARGET_HIGH: regs_d.target_high = AVS_WRITEDATA[7:0];
                IDX_BUFFER_PTR:  regs_d.buffer_ptr  = AVS_WRITEDATA[7:0];
                default:         regs_d = regs_q;
            endcase
        end
    end

    // Bus slave registers
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wait_q             <= 1'b1;
            rdata_q            <= 32'h0000_0000;
            regs_q.target_low  <= RST_TARGET_LOW;
            regs_q.target_high <= RST_TARGET_HIGH;
            regs_q.buffer_ptr  <= RST_BUFFER_PTR;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            regs_q <= regs_d;
        end
    end

    // Copy sequencer: RAM reads feed the FIFO, the FIFO feeds the array
    always_comb begin
        state_d     = state_q;
        page_mode_d = page_mode_q;
        done_d      = done_q;
        len_d       = len_q;
        base_d      = base_q;
        ptr_d       = ptr_q;
        rd_cnt_d    = rd_cnt_q;
        wr_cnt_d    = wr_cnt_q;
        ram_rd_d    = 1'b0;
        ram_vld_d   = ram_rd_q;
        ram_addr_d  = ram_addr_q;
        mem_we_d    = 1'b0;
        mem_d       = mem_q;
        hold_d      = hold_q;
        case (state_q)
            ST_IDLE: begin
                // Other codes are ignored; the command register reads as zero
                if (commit_wr && lane0 && idx == IDX_COMMAND) begin
                    if (AVS_WRITEDATA[7:0] == CMD_PAGE) begin
                        page_mode_d = 1'b1;
                        len_d       = LEN_PAGE;
                        base_d      = {regs_q.target_high, regs_q.target_low[7:PAGE_SHIFT],
                                       PAGE_SHIFT'(0)};
                    end else if (AVS_WRITEDATA[7:0] == CMD_BYTE) begin
                        page_mode_d = 1'b0;
                        len_d       = LEN_BYTE;
                        base_d      = {regs_q.target_high, regs_q.target_low};
                    end
                    if (AVS_WRITEDATA[7:0] == CMD_PAGE || AVS_WRITEDATA[7:0] == CMD_BYTE) begin
                        ptr_d    = regs_q.buffer_ptr;
                        rd_cnt_d = '0;
                        wr_cnt_d = '0;
                        done_d   = 1'b0;
                        hold_d   = 1'b1;
                        state_d  = ST_COPY;
                    end
                end
            end
            ST_COPY: begin
                // One RAM read in flight, strobe to data, keeps the FIFO from overflowing
                if (!ram_rd_q && !ram_vld_q && fifo_in_ready && rd_cnt_q != len_q) begin
                    ram_rd_d   = 1'b1;
                    ram_addr_d = ptr_q + RAM_ADDR_W'(rd_cnt_q);
                    rd_cnt_d   = rd_cnt_q + 1'b1;
                end
                if (rd_cnt_q == len_q && !ram_rd_q && !ram_vld_q) begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // Release only after the array takes and finishes the last byte
                if (wr_cnt_q == len_q && !mem_we_q && MEM_READY) begin
                    hold_d  = 1'b0;
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                hold_d  = 1'b0;
            end
        endcase
        if (fifo_pop) begin
            mem_we_d = 1'b1;
            mem_d    = fifo_out;
            wr_cnt_d = wr_cnt_q + 1'b1;
        end
    end

    // Sequencer registers
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q     <= ST_IDLE;
            page_mode_q <= 1'b0;
            done_q      <= 1'b0;
            len_q       <= '0;
            base_q      <= 16'h0000;
            ptr_q       <= 8'h00;
            rd_cnt_q    <= '0;
            wr_cnt_q    <= '0;
            ram_rd_q    <= 1'b0;
            ram_vld_q   <= 1'b0;
            ram_addr_q  <= '0;
            mem_we_q    <= 1'b0;
            mem_q       <= '0;
            hold_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            page_mode_q <= page_mode_d;
            done_q      <= done_d;
            len_q       <= len_d;
            base_q      <= base_d;
            ptr_q       <= ptr_d;
            rd_cnt_q    <= rd_cnt_d;
            wr_cnt_q    <= wr_cnt_d;
            ram_rd_q    <= ram_rd_d;
            ram_vld_q   <= ram_vld_d;
            ram_addr_q  <= ram_addr_d;
            mem_we_q    <= mem_we_d;
            mem_q       <= mem_d;
            hold_q      <= hold_d;
        end
    end

    // Outputs straight from flops
    assign AVS_READDATA    = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign RAM_ADDR        = ram_addr_q;
    assign RAM_RD          = ram_rd_q;
    assign MEM_ADDR        = mem_q.addr;
    assign MEM_WDATA       = mem_q.data;
    assign MEM_WE          = mem_we_q;
    assign CPU_HOLD        = hold_q;
endmodule

/* File: verification/program_memory_self_writer_monitor.sv */
// Checker for bus stall, copy addressing and write pulses
`timescale 1ns/1ps
module program_memory_self_writer_monitor #(
    parameter int unsigned FIFO_WORDS = 4
) (
    // Clock and reset
    input wire logic                              REF_CLK,
    input wire logic                              RESET_N,
    // Register bus
    input wire logic [isp_pkg::BUS_ADDR_W-1:0]    AVS_ADDRESS,
    input wire logic                              AVS_READ,
    input wire logic                              AVS_WRITE,
    input wire logic [31:0]                       AVS_WRITEDATA,
    input wire logic [3:0]                        AVS_BYTEENABLE,
    input wire logic [31:0]                       AVS_READDATA,
    input wire logic                              AVS_WAITREQUEST,
    // RAM and array ports
    input wire logic [isp_pkg::RAM_ADDR_W-1:0]    RAM_ADDR,
    input wire logic                              RAM_RD,
    input wire logic [7:0]                        RAM_RDATA,
    input wire logic [isp_pkg::MEM_ADDR_W-1:0]    MEM_ADDR,
    input wire logic [7:0]                        MEM_WDATA,
    input wire logic                              MEM_WE,
    input wire logic                              MEM_READY,
    // Hold
    input wire logic                              CPU_HOLD
);
    import isp_pkg::*;
    logic       cmt, go;
    logic [7:0] ptr_q, ptr_d, lo_q, lo_d, rc_q, rc_d;
    logic [3:0] hi_q, hi_d;
    logic [5:0] wc_q, wc_d;
    logic       pg_q, pg_d;
    logic [11:0] base;
    assign cmt = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    assign go = cmt && AVS_ADDRESS == 10'h250 && (AVS_WRITEDATA[7:0] == CMD_PAGE || AVS_WRITEDATA[7:0] == CMD_BYTE);
    assign base = pg_q ? {hi_q, lo_q[7:5], 5'h00} : {hi_q, lo_q};
    // Shadow of setup registers and per-copy byte counts
    always_comb begin
        ptr_d = (cmt && AVS_ADDRESS == 10'h25C) ? AVS_WRITEDATA[7:0] : ptr_q;
        lo_d = (cmt && AVS_ADDRESS == 10'h254) ? AVS_WRITEDATA[7:0] : lo_q;
        hi_d = (cmt && AVS_ADDRESS == 10'h258) ? AVS_WRITEDATA[3:0] : hi_q;
        pg_d = go ? (AVS_WRITEDATA[7:0] == CMD_PAGE) : pg_q;
        wc_d = go ? 6'h00 : wc_q + 6'(MEM_WE);
        rc_d = go ? 8'h00 : rc_q + 8'(RAM_RD);
    end
    // Register the shadows
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {ptr_q, lo_q, hi_q, pg_q, wc_q, rc_q} <= '0;
        end else begin
            {ptr_q, lo_q, hi_q, pg_q, wc_q, rc_q} <= {ptr_d, lo_d, hi_d, pg_d, wc_d, rc_d};
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    AST_RAM_ADDR: assert property (RAM_RD |-> RAM_ADDR == 8'(ptr_q + rc_q))
        else $error("RAM read address off sequence");
    AST_MEM_ADDR: assert property (MEM_WE |-> MEM_ADDR == 12'(base + 12'(wc_q)))
        else $error("array write address off sequence");
    AST_COUNT: assert property ($fell(CPU_HOLD) |-> wc_q == (pg_q ? 6'h20 : 6'h01))
        else $error("wrong number of array writes");
    AST_START: assert property (go |=> CPU_HOLD ##1 RAM_RD)
        else $error("valid command did not start copy");
    AST_STALL: assert property (CPU_HOLD |-> AVS_WAITREQUEST)
        else $error("bus answered during copy");
    AST_HOLD_END: assert property ($rose(CPU_HOLD) |-> ##[4:1000] !CPU_HOLD)
        else $error("hold never released");
    AST_WE_PULSE: assert property (MEM_WE |=> !MEM_WE)
        else $error("write pulse too long");
    AST_WE_READY: assert property (MEM_WE |-> CPU_HOLD && $past(MEM_READY))
        else $error("write while array busy or idle");
endmodule
bind program_memory_self_writer program_memory_self_writer_monitor #(.FIFO_WORDS(FIFO_WORDS)) mon_u (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .RAM_ADDR(RAM_ADDR),
    .RAM_RD(RAM_RD), .RAM_RDATA(RAM_RDATA), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_WE(MEM_WE), .MEM_READY(MEM_READY), .CPU_HOLD(CPU_HOLD));

/* File: verification/prog_array_model.sv */
// Program memory array model with adjustable programming time
`timescale 1ns/1ps
module prog_array_model (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Write port
    input wire logic [11:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        mem_we,
    output logic            mem_ready,
    // Programming time in cycles, at least 1
    input wire logic [3:0]  busy_len
);
    logic [7:0] mem [4096]; // 128 pages of 32 bytes
    logic [3:0] cnt_q;
    // Erased cells read all ones
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'hFF;
        end
    end
    // A write while busy is dropped, as a real array would lose it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            mem_ready <= 1'b1;
        end else if (mem_we && mem_ready) begin
            mem[mem_addr] <= mem_wdata;
            cnt_q <= busy_len;
            mem_ready <= 1'b0;
        end else if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            cnt_q <= 4'h0;
            mem_ready <= 1'b1;
        end
    end
endmodule

/* File: verification/tb_program_memory_self_writer.sv */
// Self-checking bench for the program memory self-writer
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_program_memory_self_writer;
    import isp_pkg::*;
    logic        ref_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0;
    logic [9:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [3:0]  avs_byteenable = 4'hF, busy_len = 4'h1;
    logic        avs_waitrequest, ram_rd, mem_we, mem_ready, cpu_hold;
    logic [7:0]  ram_addr, ram_rdata = 0, mem_wdata;
    logic [11:0] mem_addr;
    logic [7:0]  ram [256];
    int          failures = 0, total_checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    // RAM read port; idle data inverted so stale bytes never pass
    always @(posedge ref_clk) ram_rdata <= ram_rd ? ram[ram_addr] : ~ram_rdata;
    program_memory_self_writer #(.FIFO_WORDS(4)) dut_u (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .RAM_ADDR(ram_addr),
        .RAM_RD(ram_rd), .RAM_RDATA(ram_rdata), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
        .MEM_WE(mem_we), .MEM_READY(mem_ready), .CPU_HOLD(cpu_hold));
    prog_array_model arr_u (.clk(ref_clk), .rst_n(reset_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_ready(mem_ready), .busy_len(busy_len));
    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One Avalon access held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 2000);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 2000) begin
            failures++;
            $display("[ERR] %0t bus wait ran out", $time);
            end_sim();
        end
        @(posedge ref_clk);
    endtask
    // Setup in firmware order, trigger, then a status read that stalls until done
    task automatic copy(input logic [7:0] cmd, input logic [7:0] ptr, input logic [15:0] tgt);
        logic [31:0] q;
        logic        pg, ok;
        logic [11:0] base;
        pg = (cmd == CMD_PAGE);
        ok = pg || cmd == CMD_BYTE;
        base = pg ? {tgt[11:5], 5'h00} : tgt[11:0];
        bus(1, 10'h25C, ptr, 4'hF, q);
        bus(1, 10'h254, tgt[7:0], 4'hF, q);
        bus(1, 10'h258, tgt[15:8], 4'hF, q);
        bus(1, 10'h250, cmd, 4'hF, q);
        `CHK(cpu_hold, ok)
        if (!ok) begin
            // A wrongly started copy would stall this read until it ends
            bus(0, 10'h260, 8'h00, 4'hF, q);
            `CHK(q[0], 1'b0)
            `CHK(arr_u.mem[base], 8'hFF)
            return;
        end
        bus(0, 10'h260, 8'h00, 4'hF, q);
        `CHK(q[2:0], {1'b1, pg, 1'b0})
        `CHK(cpu_hold, 1'b0)
        for (int i = 0; i < (pg ? 32 : 1); i++) begin
            `CHK(arr_u.mem[12'(base + 12'(i))], ram[8'(ptr + 8'(i))])
        end
    endtask
    // Reset values, read back, lane 0 gating, unmapped place
    task automatic sc_regs;
        logic [31:0] q;
        bus(0, 10'h25C, 8'h00, 4'hF, q);
        `CHK(q, 32'h0)
        bus(0, 10'h254, 8'h00, 4'hF, q);
        `CHK(q, 32'h0)
        bus(0, 10'h258, 8'h00, 4'hF, q);
        `CHK(q, 32'h0)
        bus(0, 10'h250, 8'h00, 4'hF, q);
        `CHK(q, 32'h0)
        bus(0, 10'h3FC, 8'h00, 4'hF, q);
        `CHK(q, 32'h0)
        bus(1, 10'h25C, 8'hA5, 4'hF, q);
        bus(1, 10'h25C, 8'h3C, 4'h0, q);
        bus(0, 10'h25C, 8'h00, 4'hF, q);
        `CHK(q, 32'hA5)
    endtask
    // Unaligned target inside page 126, prompt array
    task automatic sc_page_mid;
        busy_len <= 4'h1;
        copy(CMD_PAGE, 8'h60, 16'h0FC7);
    endtask
    // First and last page, slow array fills the FIFO, RAM pointer wraps
    task automatic sc_page_ends;
        busy_len <= 4'h7;
        copy(CMD_PAGE, 8'hF0, 16'h001F);
        copy(CMD_PAGE, 8'hE0, 16'h0FE0);
    endtask
    // Byte writes back to back, upper address bits beyond the array dropped
    task automatic sc_byte;
        busy_len <= 4'h3;
        copy(CMD_BYTE, 8'h60, 16'hF105);
        copy(CMD_BYTE, 8'h61, 16'h0106);
        `CHK(arr_u.mem[12'h107], 8'hFF)
    endtask
    // Reserved codes start nothing
    task automatic sc_reserved;
        logic [7:0] codes [4] = '{8'h00, 8'h3C, 8'h5B, 8'hFF};
        foreach (codes[i]) begin
            copy(codes[i], 8'h60, 16'h0800);
        end
    endtask
    initial begin
        foreach (ram[i]) begin
            ram[i] = 8'(i * 7 + 3);
        end
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        sc_regs();
        sc_page_mid();
        sc_page_ends();
        sc_byte();
        sc_reserved();
        end_sim();
    end
endmodule
